// ==== verilog/nv_store_ctrl.sv ====
// Control, location and byte registers for the non-volatile store
`timescale 1ns/1ps
module nv_store_ctrl #(
  parameter int PROGRAM_CYCLES = nv_store_pkg::PROGRAM_CYCLES,
  parameter int FETCH_CYCLES = nv_store_pkg::FETCH_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic directSel,
  input wire logic controlSel,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic busy,
  output logic nvDoneFlag
);
  import nv_store_pkg::*;

  localparam int CNT_W = $clog2(PROGRAM_CYCLES + FETCH_CYCLES + 1);

  // Elaboration checks; the logic below cannot serve other values
  if (PROGRAM_CYCLES < 1) begin : g_bad_program
    $error("PROGRAM_CYCLES must be at least one");
  end
  if (FETCH_CYCLES < 1) begin : g_bad_fetch
    $error("FETCH_CYCLES must be at least one");
  end
  // Location read view pads exactly two zero bits
  if (ADDR_W != 6) begin : g_bad_addr
    $error("location register must be six bits wide");
  end
  if (DATA_W != 8) begin : g_bad_data
    $error("byte register must be eight bits wide");
  end
  if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
    $error("store depth must match the location width");
  end

  nv_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic [ADDR_W-1:0] location_ff, nxt_location;
  logic [DATA_W-1:0] byte_ff, nxt_byte;
  logic [3:0] control_ff, nxt_control;
  logic done_ff, nxt_done;
  logic cellWrite;
  logic [DATA_W-1:0] cellData;
  logic wrLoc, wrByte, wrCtl;
  logic rdLoc, rdByte, rdCtl;
  logic progReq, fetchReq;
  logic progAbort, fetchAbort;
  logic progEnd, fetchEnd;
  logic fetchLoad;
  logic [7:0] ctlView;
  logic [7:0] locView;

  nv_cell_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) cellArray (
    .clock(clock),
    .writeEn(cellWrite),
    .addr(location_ff),
    .writeData(byte_ff),
    .readData(cellData)
  );

  // Location and byte registers live in bank zero, direct access
  assign wrLoc = regWrite && directSel && regAddr == LOCATION_OFFSET;
  assign wrByte = regWrite && directSel && regAddr == BYTE_OFFSET;
  // Control only in bank one, reached through indirect pointer
  assign wrCtl = regWrite && controlSel && regAddr == CONTROL_OFFSET;

  // Read strobes decoded the same way as the write strobes
  assign rdLoc = regRead && directSel && regAddr == LOCATION_OFFSET;
  assign rdByte = regRead && directSel && regAddr == BYTE_OFFSET;
  assign rdCtl = regRead && controlSel && regAddr == CONTROL_OFFSET;

  // Permit must already stand; both starts in one write start nothing
  assign progReq = wrCtl && regWdata[START_PROGRAM_BIT] && !regWdata[START_FETCH_BIT]
      && control_ff[PERMIT_PROGRAM_BIT];
  assign fetchReq = wrCtl && regWdata[START_FETCH_BIT] && !regWdata[START_PROGRAM_BIT]
      && control_ff[PERMIT_FETCH_BIT];

  // Dropping a permit mid-cycle aborts; no half-written cell is left
  assign progAbort = !control_ff[PERMIT_PROGRAM_BIT];
  assign fetchAbort = !control_ff[PERMIT_FETCH_BIT];
  assign progEnd = count_ff == CNT_W'(PROGRAM_CYCLES - 1);
  assign fetchEnd = count_ff == CNT_W'(FETCH_CYCLES - 1);
  assign fetchLoad = state_ff == FETCH && !fetchAbort && fetchEnd;

  // Sequencer and control register
  always_comb begin
    nxt_state = state_ff;
    nxt_control = control_ff;
    nxt_done = 1'b0;
    cellWrite = 1'b0;
    if (wrCtl) begin
      // Permit bits always writable; start bits only take effect when idle
      nxt_control[PERMIT_PROGRAM_BIT] = regWdata[PERMIT_PROGRAM_BIT];
      nxt_control[PERMIT_FETCH_BIT] = regWdata[PERMIT_FETCH_BIT];
    end
    case (state_ff)
      IDLE: begin
        if (progReq) begin
          nxt_control[START_PROGRAM_BIT] = 1'b1;
          nxt_state = PROGRAM;
        end else if (fetchReq) begin
          nxt_control[START_FETCH_BIT] = 1'b1;
          nxt_state = FETCH;
        end
      end
      FETCH: begin
        // Start requests during the cycle are swallowed here
        nxt_control[START_FETCH_BIT] = 1'b1;
        nxt_control[START_PROGRAM_BIT] = 1'b0;
        if (fetchAbort) begin
          nxt_control[START_FETCH_BIT] = 1'b0;
          nxt_state = IDLE;
        end else if (fetchEnd) begin
          nxt_control[START_FETCH_BIT] = 1'b0;
          nxt_state = IDLE;
        end
      end
      PROGRAM: begin
        nxt_control[START_PROGRAM_BIT] = 1'b1;
        nxt_control[START_FETCH_BIT] = 1'b0;
        if (progAbort) begin
          nxt_control[START_PROGRAM_BIT] = 1'b0;
          nxt_state = IDLE;
        end else if (progEnd) begin
          cellWrite = 1'b1;
          nxt_control[START_PROGRAM_BIT] = 1'b0;
          nxt_done = 1'b1;
          nxt_state = IDLE;
        end
      end
      default: begin
        nxt_state = IDLE;
        nxt_control = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= IDLE;
      control_ff <= CONTROL_RESET[3:0];
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      control_ff <= nxt_control;
      done_ff <= nxt_done;
    end
  end

  // Cycle counter; cleared whenever the sequencer idles
  always_comb begin
    nxt_count = '0;
    if (state_ff != IDLE) begin
      nxt_count = count_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Location and byte registers; a finished fetch overwrites the byte
  always_comb begin
    nxt_location = location_ff;
    nxt_byte = byte_ff;
    if (wrLoc) begin
      nxt_location = regWdata[ADDR_W-1:0];
    end
    if (wrByte) begin
      nxt_byte = regWdata;
    end
    if (fetchLoad) begin
      nxt_byte = cellData;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      location_ff <= LOCATION_RESET[ADDR_W-1:0];
      byte_ff <= BYTE_RESET;
    end else begin
      location_ff <= nxt_location;
      byte_ff <= nxt_byte;
    end
  end

  // Unimplemented control bits read zero
  for (genvar i = 0; i < 8; i++) begin : g_ctl_view
    if (i < 4) begin : g_impl
      assign ctlView[i] = control_ff[i];
    end else begin : g_unimpl
      assign ctlView[i] = 1'b0;
    end
  end

  assign locView = {2'b00, location_ff};

  // Read mux; unmapped addresses read zero
  always_comb begin
    regRdata = 8'h00;
    if (rdLoc) begin
      regRdata = locView;
    end else if (rdByte) begin
      regRdata = byte_ff;
    end else if (rdCtl) begin
      regRdata = ctlView;
    end
  end

  assign busy = state_ff != IDLE;
  assign nvDoneFlag = done_ff;
endmodule

// ==== verilog/nv_store_pkg.sv ====
// Package of constants for the non-volatile byte store controller
package nv_store_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int DEPTH = 64;
  localparam logic [7:0] LOCATION_OFFSET = 8'h1E;
  localparam logic [7:0] BYTE_OFFSET = 8'h1F;
  localparam logic [7:0] CONTROL_OFFSET = 8'h40;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] LOCATION_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int PERMIT_PROGRAM_BIT = 3;
  localparam int START_PROGRAM_BIT = 2;
  localparam int PERMIT_FETCH_BIT = 1;
  localparam int START_FETCH_BIT = 0;
  // Write time in ns and its cycle count at 250 MHz
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int PROGRAM_TIME_NS = 4000;
  localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int FETCH_TIME_NS = 8;
  localparam int FETCH_CYCLES = (FETCH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    FETCH = 3'b010,
    PROGRAM = 3'b100
  } nv_state_t;
endpackage

// ==== verilog/nv_cell_array.sv ====
// Byte array modelling the non-volatile cells
`timescale 1ns/1ps
module nv_cell_array #(
  parameter int ADDR_W = nv_store_pkg::ADDR_W,
  parameter int DATA_W = nv_store_pkg::DATA_W
) (
  input wire logic clock,
  input wire logic writeEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] writeData,
  output logic [DATA_W-1:0] readData
);
  import nv_store_pkg::*;
  // No reset: contents survive a reset, as a non-volatile store would
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
  always_ff @(posedge clock) begin
    if (writeEn) begin
      cells[addr] <= writeData;
    end
  end
  assign readData = cells[addr];
endmodule

// ==== test/nv_store_checker.sv ====
// Checker for the store controller ports
`timescale 1ns/1ps
module nv_store_checker #(
  parameter int PROGRAM_CYCLES = 4,
  parameter int FETCH_CYCLES = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic directSel,
  input wire logic controlSel,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic busy,
  input wire logic nvDoneFlag
);
  localparam int PD = PROGRAM_CYCLES - 1;
  localparam int FD = FETCH_CYCLES - 1;
  logic [7:0] permitFf;
  wire ctlWr = controlSel && regAddr == 8'h40 && regWrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Mirror of the permits, so refusals can be judged
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst) permitFf <= 8'h00;
    else if (ctlWr) permitFf <= regWdata;
  sequence fetchGo; ctlWr && regWdata == 8'h03 && !busy ##1 busy; endsequence
  sequence progGo; ctlWr && regWdata == 8'h0C && !busy ##1 busy; endsequence
  a_ctl_upper_zero: assert property (controlSel && regRead |-> regRdata[7:4] == 4'h0)
    else $error("control upper bits set");
  a_loc_upper_zero: assert property (directSel && regRead && regAddr == 8'h1E |->
    regRdata[7:6] == 2'b00) else $error("location upper bits set");
  a_fetch_timing: assert property (fetchGo |-> ##FD busy ##1 !busy)
    else $error("fetch length wrong");
  a_prog_timing: assert property (progGo |-> ##PD busy ##1 (!busy && nvDoneFlag))
    else $error("program length or done wrong");
  a_fetch_refused: assert property (ctlWr && regWdata[0] && !permitFf[1] && !busy |=> !busy)
    else $error("fetch without permit");
  a_prog_refused: assert property (ctlWr && regWdata[2] && !permitFf[3] && !busy |=> !busy)
    else $error("program without permit");
  a_both_refused: assert property (ctlWr && regWdata[2] && regWdata[0] && !busy |=> !busy)
    else $error("double start taken");
  a_done_pulse: assert property (nvDoneFlag |=> !nvDoneFlag)
    else $error("done longer than one cycle");
endmodule
bind nv_store_ctrl nv_store_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES),
  .FETCH_CYCLES(FETCH_CYCLES)) u_chk (.*);

// ==== test/core_model.sv ====
// Core model issuing register accesses
`timescale 1ns/1ps
module core_model (
  input wire logic clock,
  output logic directSel,
  output logic controlSel,
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial {directSel, controlSel, regAddr, regWrite, regRead, regWdata} = '0;
  task automatic acc(input logic c, w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clock);
    controlSel = c;
    directSel = !c;
    regAddr = a;
    regWrite = w;
    regRead = !w;
    regWdata = d;
    @(posedge clock) q = regRdata;
    @(negedge clock);
    {directSel, controlSel, regWrite, regRead} = '0;
    regWdata = ~d; // Released data bus never keeps a stale value; regAddr holds the last address
  endtask
endmodule

// ==== test/byte_eeprom_access_control_test.sv ====
// Self-checking bench for the store controller
`timescale 1ns/1ps
module byte_eeprom_access_control_test;
  import nv_store_pkg::*;
  logic clock = 0, sys_rst = 1, directSel, controlSel, regWrite, regRead, busy, nvDoneFlag;
  logic [7:0] regAddr, regWdata, regRdata, q, d, mem [64];
  logic [5:0] adr [6];
  int badCount = 0, nCompared = 0, doneCount = 0, seed = 32'h101e_77f1;
  initial forever #2 clock = ~clock;
  // Short counts keep the run brief
  nv_store_ctrl #(.PROGRAM_CYCLES(4), .FETCH_CYCLES(2)) u_dut (.*);
  core_model u_core (.*);
  always @(posedge clock) if (nvDoneFlag === 1'b1) doneCount++;
  function automatic logic [7:0] locView(input logic [7:0] v); return {2'b00, v[5:0]}; endfunction
  task automatic chk(input logic [7:0] got, exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic c, input logic [7:0] a, v); u_core.acc(c, 1, a, v, q); endtask
  task automatic rd(input logic c, input logic [7:0] a); u_core.acc(c, 0, a, 8'h00, q); endtask
  task automatic settle; repeat (20) if (busy === 1'b1) @(negedge clock); endtask
  task report_and_stop;
    $display("compared %0d, wrong %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 0;
    rd(0, LOCATION_OFFSET); chk(q, LOCATION_RESET);
    rd(0, BYTE_OFFSET); chk(q, BYTE_RESET);
    rd(1, CONTROL_OFFSET); chk(q, CONTROL_RESET);
    wr(1, CONTROL_OFFSET, 8'hF0); rd(1, CONTROL_OFFSET); chk(q, 8'h00);
    wr(1, CONTROL_OFFSET, 8'h04); chk({7'h0, busy}, 8'h00);
    wr(1, CONTROL_OFFSET, 8'h01); chk({7'h0, busy}, 8'h00);
    $display("reset and refusal test done");
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      adr[i] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($random(seed));
      wr(0, LOCATION_OFFSET, {d[7:6], adr[i]});
      rd(0, LOCATION_OFFSET); chk(q, locView({d[7:6], adr[i]}));
      wr(0, BYTE_OFFSET, d);
      wr(1, CONTROL_OFFSET, 8'h08);
      wr(1, CONTROL_OFFSET, 8'h0C);
      settle;
      rd(1, CONTROL_OFFSET); chk(q, 8'h08);
      mem[adr[i]] = d;
    end
    chk(8'(doneCount), 8'h06);
    $display("program test done");
    wr(1, CONTROL_OFFSET, 8'h0F); chk({7'h0, busy}, 8'h00);
    wr(1, CONTROL_OFFSET, 8'h00);
    wr(0, LOCATION_OFFSET, {2'b00, adr[0]});
    wr(0, BYTE_OFFSET, ~mem[adr[0]]);
    wr(1, CONTROL_OFFSET, 8'h04);
    wr(1, CONTROL_OFFSET, 8'h01); settle;
    rd(0, BYTE_OFFSET); chk(q, ~mem[adr[0]]);
    chk(8'(doneCount), 8'h06);
    for (int i = 0; i < 6; i++) begin
      wr(0, BYTE_OFFSET, ~mem[adr[i]]);
      wr(1, CONTROL_OFFSET, 8'h02);
      wr(0, LOCATION_OFFSET, {2'b00, adr[i]});
      wr(1, CONTROL_OFFSET, 8'h03);
      settle;
      rd(1, CONTROL_OFFSET); chk(q, 8'h02);
      rd(0, BYTE_OFFSET); chk(q, mem[adr[i]]);
    end
    $display("fetch test done");
    report_and_stop;
  end
  // Whole run needs a few hundred cycles; this bound only cuts a hang
  initial begin
    #40000;
    badCount++;
    report_and_stop;
  end
endmodule
